// [rtl/ctc_pkg.sv]
// package of the transceiver mode control: modes, register map, timing
// assumes a 125 MHz system clock; all times below are in nanoseconds
`default_nettype none

package ctc_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int CLK_PERIOD_NS    = 8;
    localparam int FILTER_NS        = 1000;
    localparam int WAKE_REACT_NS    = 2000;
    localparam int MODE_CHANGE_NS   = 20000;
    localparam int TXD_TIMEOUT_NS   = 1000000;
    // least times round up, longest times round down
    localparam int FILTER_CYC       = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_REACT_CYC   = WAKE_REACT_NS / CLK_PERIOD_NS;
    localparam int MODE_CHANGE_CYC  = MODE_CHANGE_NS / CLK_PERIOD_NS;
    localparam int TXD_TIMEOUT_CYC  = (TXD_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_PATH_CYC    = 2;
    localparam int CNT_W            = 24;
    localparam int FILT_W           = 16;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [11:0] REG_CTRL_ADDR   = 12'h000;
    localparam logic [11:0] REG_STATUS_ADDR = 12'h004;
    localparam logic [FILT_W-1:0] CTRL_RESET = FILT_W'(FILTER_CYC);
    localparam int ST_MODE_LSB   = 0;
    localparam int ST_CHANGE_BIT = 2;
    localparam int ST_TMO_BIT    = 3;
    localparam int ST_OT_BIT     = 4;
    localparam int ST_WAKE_BIT   = 5;
    localparam int ST_ARMED_BIT  = 6;

    // ************************************************************
    // modes
    // ************************************************************
    typedef enum logic [1:0] {
        MODE_POWER_DOWN = 2'b00,
        MODE_STANDBY    = 2'b01,
        MODE_FORCED     = 2'b10,
        MODE_NORMAL     = 2'b11
    } ctc_mode_type;

endpackage

`default_nettype wire

// [rtl/ctc_sub_if.sv]
// bundle between the mode controller and its wake filter and tx watchdog
// assumes all three modules share one clock
`default_nettype none

interface ctc_sub_if;
    import ctc_pkg::*;
    logic              filt_en;
    logic              filt_raw;
    logic [FILT_W-1:0] filt_limit;
    logic              filt_level;
    logic              tmo_en;
    logic              tmo_txd;
    logic              tmo_flag;

    modport ctl  (output filt_en, filt_raw, filt_limit, tmo_en, tmo_txd,
                  input  filt_level, tmo_flag);
    modport filt (input  filt_en, filt_raw, filt_limit, output filt_level);
    modport tmo  (input  tmo_en, tmo_txd, output tmo_flag);
endinterface

`default_nettype wire

// [rtl/ctc_wake_filter.sv]
// activity filter of the low-power receiver
// assumes filt_raw is high for a dominant bus, synchronous to clock
`default_nettype none

module ctc_wake_filter
    import ctc_pkg::*;
(
    input  wire logic clock,
    input  wire logic sys_rst,
    ctc_sub_if.filt   sub
);
    logic [FILT_W-1:0] cnt_r;
    logic [FILT_W-1:0] cnt_nxt;
    logic              level_r;
    logic              level_nxt;

    // ************************************************************
    // while enabled, level changes only after it has differed for the full limit
    // ************************************************************
    always_comb begin
        cnt_nxt   = '0;
        level_nxt = level_r;
        if (!sub.filt_en) begin
            level_nxt = 1'b0;
        end else if (sub.filt_raw != level_r) begin
            if (cnt_r >= sub.filt_limit) begin
                level_nxt = sub.filt_raw;
            end else begin
                cnt_nxt = cnt_r + FILT_W'(1);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt_r   <= '0;
            level_r <= 1'b0;
        end else begin
            cnt_r   <= cnt_nxt;
            level_r <= level_nxt;
        end
    end

    assign sub.filt_level = level_r;
endmodule

`default_nettype wire

// [rtl/ctc_tx_watchdog.sv]
// transmit-dominant time-out watchdog
// assumes tmo_en is high only in normal-operating mode
`default_nettype none

module ctc_tx_watchdog
    import ctc_pkg::*;
#(
    parameter int LIMIT = TXD_TIMEOUT_CYC
) (
    input  wire logic clock,
    input  wire logic sys_rst,
    ctc_sub_if.tmo    sub
);
    generate
        if (LIMIT < 1 || LIMIT >= (1 << CNT_W)) begin : g_bad
            $error("tx time-out limit out of range");
        end
    endgenerate

    localparam logic [CNT_W-1:0] LIM = CNT_W'(LIMIT);

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             flag_r;
    logic             flag_nxt;
    logic             txd_q_r;
    logic             txd_q_nxt;

    // ************************************************************
    // count low time; a rising txd or a low tmo_en releases the flag
    // ************************************************************
    always_comb begin
        txd_q_nxt = sub.tmo_txd;
        cnt_nxt   = '0;
        flag_nxt  = flag_r;
        if (!sub.tmo_en) begin
            flag_nxt = 1'b0;
        end else if (!sub.tmo_txd) begin
            if (cnt_r >= LIM) begin
                flag_nxt = 1'b1;
                cnt_nxt  = cnt_r;
            end else begin
                cnt_nxt = cnt_r + CNT_W'(1);
            end
        end else if (!txd_q_r) begin
            flag_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt_r   <= '0;
            flag_r  <= 1'b0;
            txd_q_r <= 1'b1;
        end else begin
            cnt_r   <= cnt_nxt;
            flag_r  <= flag_nxt;
            txd_q_r <= txd_q_nxt;
        end
    end

    assign sub.tmo_flag = flag_r;
endmodule

`default_nettype wire

// [rtl/ctc_mode_ctrl.sv]
// mode control of a high-speed CAN transceiver, with an APB register port
// assumes supply-good flags, receiver outputs and pins are synchronous to clock
//
// Notes on behaviour
// - logic supply absent: power-down, bus floats
// - forced stand-by: transmitter and normal receiver off
// - forced stand-by: low-power receiver shows wake-ups
// - forced stand-by: bus biased to ground
// - forced stand-by only without transmitter supply
// - standby select high leaves forced stand-by
// - power up on logic supply, default stand-by
// - power-up, logic supply only: select picks mode
// - logic supply undervoltage wins, power-down
// - transmitter undervoltage: forced stand-by
// - transmitter undervoltage checked only in normal
// - both stand-by modes report wake-up on receive
// - receive high until recessive-to-dominant seen
// - only pulses longer than filter time pass
// - receive updated within wake-up reaction time
// - wake-up never changes mode by itself
// - stand-by wake-up works without transmitter supply
// - open inputs read high, giving stand-by
// - long low transmit data disables transmitter
// - transmitter back only after transmit rising edge; here leaving normal mode also releases the time-out
// - overtemperature blocks transmitter in normal only
// - mode change timed, receive held high
// - both supplies, select low: normal mode
// - normal: transmit drives bus, receive mirrors bus
// - select high gives stand-by regardless of transmitter supply
`default_nettype none

module ctc_mode_ctrl
    import ctc_pkg::*;
#(
    parameter int TXD_TMO_CYC = TXD_TIMEOUT_CYC,
    parameter int MODE_CYC    = MODE_CHANGE_CYC
) (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        logic_supply_ok,
    input  wire logic        transmitter_supply_ok,
    input  wire logic        standby_select,
    input  wire logic        txd,
    input  wire logic        overtemp,
    input  wire logic        normal_rx_dominant,
    input  wire logic        lp_rx_dominant,
    output var  logic        rxd,
    output var  logic        tx_drive_dominant,
    output var  logic        tx_enable,
    output var  logic        normal_rx_enable,
    output var  logic        lp_rx_enable,
    output var  logic        bias_mid,
    output var  logic        bias_gnd
);
    // ************************************************************
    // elaboration checks
    // ************************************************************
    generate
        if (MODE_CYC < 1 || MODE_CYC >= (1 << CNT_W)) begin : g_bad_mode
            $error("mode change count out of range");
        end
        if (WAKE_PATH_CYC > WAKE_REACT_CYC) begin : g_bad_wake
            $error("wake path slower than reaction time");
        end
    endgenerate

    localparam logic [CNT_W-1:0] MODE_LIM = CNT_W'(MODE_CYC);

    // ************************************************************
    // sub-blocks
    // ************************************************************
    ctc_sub_if sub ();

    ctc_wake_filter u_filt (
        .clock   (clock),
        .sys_rst (sys_rst),
        .sub     (sub.filt)
    );

    ctc_tx_watchdog #(
        .LIMIT (TXD_TMO_CYC)
    ) u_tmo (
        .clock   (clock),
        .sys_rst (sys_rst),
        .sub     (sub.tmo)
    );

    // ************************************************************
    // state
    // ************************************************************
    ctc_mode_type      mode_r;
    ctc_mode_type      mode_nxt;
    logic [CNT_W-1:0]  chg_cnt_r;
    logic [CNT_W-1:0]  chg_cnt_nxt;
    logic              armed_r;
    logic              armed_nxt;
    logic              filt_q_r;
    logic              filt_q_nxt;
    logic              wake_seen_r;
    logic              wake_seen_nxt;
    logic [FILT_W-1:0] ctrl_r;
    logic [FILT_W-1:0] ctrl_nxt;
    logic              rxd_nxt;
    logic              tx_dom_nxt;
    logic              tx_en_nxt;
    logic              nrx_en_nxt;
    logic              lprx_en_nxt;
    logic              bias_mid_nxt;
    logic              bias_gnd_nxt;
    logic [31:0]       prdata_nxt;
    logic              pready_nxt;
    logic              pslverr_nxt;

    logic changing;
    logic low_power;
    logic ot_block;
    logic wr_en;
    logic rd_phase;

    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == REG_CTRL_ADDR) || (a == REG_STATUS_ADDR);
    endfunction

    assign changing  = (chg_cnt_r != '0);
    assign low_power = (mode_r == MODE_STANDBY) || (mode_r == MODE_FORCED);
    assign ot_block  = (mode_nxt == MODE_NORMAL) && overtemp;

    // ************************************************************
    // mode selection
    // ************************************************************
    // standby_select arrives already high when left open, pull-up outside
    always_comb begin
        mode_nxt = mode_r;
        if (!logic_supply_ok) begin
            mode_nxt = MODE_POWER_DOWN;
        end else begin
            case (mode_r)
                MODE_POWER_DOWN: begin
                    if (standby_select) begin
                        mode_nxt = MODE_STANDBY;
                    end else if (transmitter_supply_ok) begin
                        mode_nxt = MODE_NORMAL;
                    end else begin
                        mode_nxt = MODE_FORCED;
                    end
                end
                MODE_STANDBY: begin
                    // without the transmitter supply it stays here
                    if (!standby_select && transmitter_supply_ok) begin
                        mode_nxt = MODE_NORMAL;
                    end
                end
                MODE_FORCED: begin
                    if (standby_select) begin
                        mode_nxt = MODE_STANDBY;
                    end else if (transmitter_supply_ok) begin
                        mode_nxt = MODE_NORMAL;
                    end
                end
                MODE_NORMAL: begin
                    if (standby_select) begin
                        mode_nxt = MODE_STANDBY;
                    end else if (!transmitter_supply_ok) begin
                        mode_nxt = MODE_FORCED;
                    end
                end
                default: mode_nxt = MODE_POWER_DOWN;
            endcase
        end
    end

    // ************************************************************
    // mode-change timer and wake arming
    // ************************************************************
    always_comb begin
        chg_cnt_nxt = '0;
        if (mode_nxt != mode_r && mode_nxt != MODE_POWER_DOWN) begin
            chg_cnt_nxt = MODE_LIM;
        end else if (mode_nxt != MODE_POWER_DOWN && changing) begin
            chg_cnt_nxt = chg_cnt_r - CNT_W'(1);
        end
    end

    always_comb begin
        filt_q_nxt    = sub.filt_level;
        armed_nxt     = armed_r;
        wake_seen_nxt = wake_seen_r;
        if (mode_nxt != mode_r || !low_power) begin
            armed_nxt = 1'b0;
        end else if (sub.filt_level && !filt_q_r) begin
            armed_nxt = 1'b1;
        end
        if (low_power && sub.filt_level && !filt_q_r) begin
            wake_seen_nxt = 1'b1;
        end else if (wr_en && paddr == REG_STATUS_ADDR && pwdata[ST_WAKE_BIT]) begin
            wake_seen_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mode_r      <= MODE_POWER_DOWN;
            chg_cnt_r   <= '0;
            armed_r     <= 1'b0;
            filt_q_r    <= 1'b0;
            wake_seen_r <= 1'b0;
        end else begin
            mode_r      <= mode_nxt;
            chg_cnt_r   <= chg_cnt_nxt;
            armed_r     <= armed_nxt;
            filt_q_r    <= filt_q_nxt;
            wake_seen_r <= wake_seen_nxt;
        end
    end

    // ************************************************************
    // sub-block drive
    // ************************************************************
    assign sub.filt_en    = low_power && !changing;
    assign sub.filt_raw   = lp_rx_dominant;
    assign sub.filt_limit = ctrl_r;
    assign sub.tmo_en     = (mode_r == MODE_NORMAL);
    assign sub.tmo_txd    = txd;

    // ************************************************************
    // pin outputs
    // ************************************************************
    always_comb begin
        rxd_nxt      = 1'b1;
        tx_dom_nxt   = 1'b0;
        tx_en_nxt    = 1'b0;
        nrx_en_nxt   = 1'b0;
        lprx_en_nxt  = 1'b0;
        bias_mid_nxt = 1'b0;
        bias_gnd_nxt = 1'b0;
        case (mode_nxt)
            MODE_NORMAL: begin
                nrx_en_nxt   = 1'b1;
                bias_mid_nxt = 1'b1;
                tx_en_nxt    = !sub.tmo_flag && !ot_block;
                tx_dom_nxt   = tx_en_nxt && !txd && !changing;
                if (!changing) begin
                    rxd_nxt = !normal_rx_dominant;
                end
            end
            MODE_STANDBY, MODE_FORCED: begin
                lprx_en_nxt  = 1'b1;
                bias_gnd_nxt = 1'b1;
                if (!changing && armed_r) begin
                    rxd_nxt = !sub.filt_level;
                end
            end
            default: begin
                rxd_nxt = 1'b1;
            end
        endcase
        if (mode_nxt != mode_r) begin
            rxd_nxt    = 1'b1;
            tx_dom_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rxd               <= 1'b1;
            tx_drive_dominant <= 1'b0;
            tx_enable         <= 1'b0;
            normal_rx_enable  <= 1'b0;
            lp_rx_enable      <= 1'b0;
            bias_mid          <= 1'b0;
            bias_gnd          <= 1'b0;
        end else begin
            rxd               <= rxd_nxt;
            tx_drive_dominant <= tx_dom_nxt;
            tx_enable         <= tx_en_nxt;
            normal_rx_enable  <= nrx_en_nxt;
            lp_rx_enable      <= lprx_en_nxt;
            bias_mid          <= bias_mid_nxt;
            bias_gnd          <= bias_gnd_nxt;
        end
    end

    // ************************************************************
    // apb slave, one wait state so read data comes from a flop
    // ************************************************************
    assign rd_phase = psel && penable && !pready;
    assign wr_en    = psel && penable && pready && pwrite && !pslverr;

    always_comb begin
        pready_nxt  = rd_phase;
        pslverr_nxt = rd_phase && !addr_hit(paddr);
        prdata_nxt  = '0;
        ctrl_nxt    = ctrl_r;
        if (rd_phase && !pwrite) begin
            case (paddr)
                REG_CTRL_ADDR: prdata_nxt[FILT_W-1:0] = ctrl_r;
                REG_STATUS_ADDR: begin
                    prdata_nxt[ST_MODE_LSB +: 2] = mode_r;
                    prdata_nxt[ST_CHANGE_BIT]    = changing;
                    prdata_nxt[ST_TMO_BIT]       = sub.tmo_flag;
                    prdata_nxt[ST_OT_BIT]        = ot_block;
                    prdata_nxt[ST_WAKE_BIT]      = wake_seen_r;
                    prdata_nxt[ST_ARMED_BIT]     = armed_r;
                end
                default: prdata_nxt = '0;
            endcase
        end
        // a zero limit would pass every glitch, so it is refused
        if (wr_en && paddr == REG_CTRL_ADDR && pwdata[FILT_W-1:0] != '0) begin
            ctrl_nxt = pwdata[FILT_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            ctrl_r  <= CTRL_RESET;
        end else begin
            prdata  <= prdata_nxt;
            pready  <= pready_nxt;
            pslverr <= pslverr_nxt;
            ctrl_r  <= ctrl_nxt;
        end
    end
endmodule

`default_nettype wire

// [verif/ctc_bus_model.sv]
// far-side bus model: wired dominance of this node and one remote node
// assumes the transmitter output is registered to clock
`default_nettype none

module ctc_bus_model (
    input  wire logic clock,
    input  wire logic tx_drive_dominant,
    input  wire logic remote_dom,
    output var  logic normal_rx_dominant,
    output var  logic lp_rx_dominant
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // bus
    // ****
    // dominant wins; the normal receiver adds one cycle of loop delay
    always_ff @(posedge clock) begin
        normal_rx_dominant <= tx_drive_dominant | remote_dom;
    end
    // the low-power receiver sees the raw bus, the filter is the block's job
    assign lp_rx_dominant = tx_drive_dominant | remote_dom;
endmodule

`default_nettype wire

// [verif/ctc_mode_checker.sv]
// concurrent checks on the top ports of the mode controller
// assumes one clock and a synchronous active-high reset
`default_nettype none

module ctc_mode_checker
    import ctc_pkg::*;
#(
    parameter int TXD_TMO_CYC = TXD_TIMEOUT_CYC,
    parameter int MODE_CYC    = MODE_CHANGE_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic logic_supply_ok,
    input wire logic standby_select,
    input wire logic txd,
    input wire logic overtemp,
    input wire logic normal_rx_dominant,
    input wire logic rxd,
    input wire logic tx_drive_dominant,
    input wire logic tx_enable,
    input wire logic normal_rx_enable,
    input wire logic lp_rx_enable,
    input wire logic bias_mid,
    input wire logic bias_gnd
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] low_cnt_r, low_cnt_nxt, norm_cnt_r, norm_cnt_nxt;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // ****
    // helper counters
    // ****
    // saturate so a stuck pin cannot wrap the count under the limit
    always_comb begin
        low_cnt_nxt  = (txd || !normal_rx_enable) ? 8'h00 : low_cnt_r + {7'h00, ~&low_cnt_r};
        norm_cnt_nxt = !normal_rx_enable ? 8'h00 : norm_cnt_r + {7'h00, ~&norm_cnt_r};
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            low_cnt_r  <= 8'h00;
            norm_cnt_r <= 8'h00;
        end else begin
            low_cnt_r  <= low_cnt_nxt;
            norm_cnt_r <= norm_cnt_nxt;
        end
    end
    // ****
    // assertions
    // ****
    pd_float_a: assert property (!logic_supply_ok |=> rxd && !bias_mid
        && !bias_gnd && !lp_rx_enable && !tx_enable) else $error("power-down outputs wrong");
    stby_path_a: assert property (bias_gnd |-> lp_rx_enable && !bias_mid
        && !tx_enable && !normal_rx_enable) else $error("stand-by path wrong");
    norm_path_a: assert property (tx_enable |-> bias_mid && normal_rx_enable
        && !lp_rx_enable) else $error("normal path wrong");
    sel_high_a: assert property (logic_supply_ok && standby_select |=>
        !tx_enable && !normal_rx_enable) else $error("select high left tx on");
    drive_src_a: assert property (tx_drive_dominant |-> tx_enable && !$past(txd))
        else $error("dominant without request");
    ot_block_a: assert property (overtemp |=> !tx_enable)
        else $error("tx on during overtemperature");
    // slack is generous; the watchdog counts from the first cycle in normal mode, change or not
    tx_tmo_a: assert property (int'(low_cnt_r) > TXD_TMO_CYC + MODE_CYC + 4 |-> !tx_enable)
        else $error("tx time-out missed");
    rx_follow_a: assert property (int'(norm_cnt_r) > MODE_CYC + 3 && normal_rx_dominant
        |=> !rxd || !normal_rx_enable) else $error("rxd not following bus");
    chg_hold_a: assert property ($rose(bias_gnd) |-> (rxd && !tx_drive_dominant) [*8])
        else $error("rxd not held during change");
    apb_ans_a: assert property (psel && $rose(penable) |=> pready) else $error("no apb answer");
    cover property (tx_enable && !txd);
    cover property ($rose(bias_gnd));
    cover property (pready && pslverr);
endmodule

bind ctc_mode_ctrl ctc_mode_checker #(.TXD_TMO_CYC(TXD_TMO_CYC), .MODE_CYC(MODE_CYC))
    i_ctc_mode_checker (.clock, .sys_rst, .psel, .penable, .pready, .pslverr,
    .logic_supply_ok, .standby_select, .txd, .overtemp, .normal_rx_dominant, .rxd,
    .tx_drive_dominant, .tx_enable, .normal_rx_enable, .lp_rx_enable, .bias_mid, .bias_gnd);

`default_nettype wire

// [verif/tb_ctc_mode_ctrl.sv]
// self-checking bench of the transceiver mode control
// assumes the bus model and the checker are compiled before it
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fail_count++; \
    $display("wrong value %s exp %0h got %0h", n, e, a); end end

module tb_ctc_mode_ctrl;
    import ctc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // short counts keep the run small
    localparam int TMO = 50;
    localparam int MCH = 8;
    logic        clock = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        logic_supply_ok = 1'b0, transmitter_supply_ok = 1'b0, overtemp = 1'b0;
    logic        standby_select = 1'b1, txd = 1'b1, remote_dom = 1'b0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, normal_rx_dominant, lp_rx_dominant, rxd, tx_drive_dominant;
    logic        tx_enable, normal_rx_enable, lp_rx_enable, bias_mid, bias_gnd;
    int          fail_count = 0, checks = 0;
    // ****
    // harness
    // ****
    always #4 clock = ~clock;
    ctc_mode_ctrl #(.TXD_TMO_CYC(TMO), .MODE_CYC(MCH)) i_ctc_mode_ctrl (.clock, .sys_rst,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .logic_supply_ok, .transmitter_supply_ok, .standby_select, .txd, .overtemp,
        .normal_rx_dominant, .lp_rx_dominant, .rxd, .tx_drive_dominant, .tx_enable,
        .normal_rx_enable, .lp_rx_enable, .bias_mid, .bias_gnd);
    ctc_bus_model i_ctc_bus_model (.clock, .tx_drive_dominant, .remote_dom,
        .normal_rx_dominant, .lp_rx_dominant);
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    // values read right after an edge are those sampled at that edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1);
        `CHK("wait states", 2, n)
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic mode_is(input logic [1:0] m);
        apb(1'b0, REG_STATUS_ADDR, 32'h0);
        `CHK("mode", m, rd[1:0])
    endtask
    task automatic pins(input logic l, input logic t, input logic s);
        @(posedge clock);
        logic_supply_ok       <= l;
        transmitter_supply_ok <= t;
        standby_select        <= s;
        cyc(MCH + 6);
    endtask
    task automatic end_sim;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_regs;
        apb(1'b0, REG_CTRL_ADDR, 32'h0);
        `CHK("ctrl reset", 32'h0000007d, rd)
        apb(1'b0, 12'h010, 32'h0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
        apb(1'b1, REG_CTRL_ADDR, 32'hffff0004);
        apb(1'b0, REG_CTRL_ADDR, 32'h0);
        `CHK("ctrl rw", 32'h00000004, rd)
        mode_is(2'd0);
    endtask
    task automatic t_power;
        pins(1'b1, 1'b0, 1'b1);
        mode_is(2'd1);
        `CHK("open bias", 1'b1, bias_gnd)
        pins(1'b0, 1'b0, 1'b1);
        pins(1'b1, 1'b0, 1'b0);
        mode_is(2'd2);
        `CHK("forced bias", 1'b1, bias_gnd)
        `CHK("forced tx", 1'b0, tx_enable | normal_rx_enable)
        `CHK("forced lp", 1'b1, lp_rx_enable)
        pins(1'b1, 1'b0, 1'b1);
        mode_is(2'd1);
        pins(1'b1, 1'b0, 1'b0);
        mode_is(2'd1);
        pins(1'b1, 1'b1, 1'b0);
        mode_is(2'd3);
        `CHK("normal bias", 1'b1, bias_mid)
        pins(1'b1, 1'b0, 1'b0);
        mode_is(2'd2);
        pins(1'b0, 1'b1, 1'b0);
        mode_is(2'd0);
        `CHK("pd bias", 1'b0, bias_mid | bias_gnd)
    endtask
    task automatic t_tx;
        pins(1'b1, 1'b1, 1'b0);
        txd <= 1'b0;
        cyc(4);
        `CHK("drive", 1'b1, tx_drive_dominant)
        `CHK("rxd dom", 1'b0, rxd)
        cyc(TMO + 6);
        `CHK("tmo tx", 1'b0, tx_enable | tx_drive_dominant)
        remote_dom <= 1'b1;
        cyc(4);
        `CHK("tmo rx", 1'b0, rxd)
        `CHK("tmo held", 1'b0, tx_enable)
        remote_dom <= 1'b0;
        txd <= 1'b1;
        cyc(3);
        `CHK("tx back", 1'b1, tx_enable)
        overtemp <= 1'b1;
        cyc(3);
        `CHK("ot tx", 1'b0, tx_enable)
        mode_is(2'd3);
        overtemp <= 1'b0;
        cyc(3);
        `CHK("ot clear", 1'b1, tx_enable)
    endtask
    task automatic t_wake;
        pins(1'b1, 1'b0, 1'b1);
        mode_is(2'd1);
        `CHK("stby rxd", 1'b1, rxd)
        remote_dom <= 1'b1;
        cyc(2);
        remote_dom <= 1'b0;
        cyc(12);
        `CHK("glitch", 1'b1, rxd)
        remote_dom <= 1'b1;
        cyc(3);
        `CHK("early", 1'b1, rxd)
        cyc(9);
        `CHK("wake rxd", 1'b0, rxd)
        remote_dom <= 1'b0;
        cyc(12);
        `CHK("wake rec", 1'b1, rxd)
        overtemp <= 1'b1;
        cyc(3);
        mode_is(2'd1);
        `CHK("wake seen", 1'b1, rd[ST_WAKE_BIT])
        overtemp              <= 1'b0;
        standby_select        <= 1'b0;
        transmitter_supply_ok <= 1'b1;
        remote_dom            <= 1'b1;
        cyc(4);
        `CHK("change rxd", 1'b1, rxd)
        cyc(MCH + 4);
        `CHK("after change", 1'b0, rxd)
    endtask
    initial begin
        cyc(6);
        sys_rst <= 1'b0;
        @(posedge clock);
        t_regs();
        t_power();
        t_tx();
        t_wake();
        end_sim();
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        #100000;
        fail_count++;
        end_sim();
    end
endmodule

`default_nettype wire
